// File: rtl/i2c_port_defines.vh
// constants of the serial control port: address, register indices, timing
// assumes a 100 MHz core clock sampling the two-wire bus
`ifndef I2C_PORT_DEFINES_VH
`define I2C_PORT_DEFINES_VH
`define ADDR_UPPER        5'h0D
`define REG_IRQ_INDEX     8'h02
`define REG_VBAT_INDEX    8'h6D
`define REG_TEMP_INDEX    8'h6E
`define IRQ_UV_BIT        14
`define BUS_RATE_KHZ      400
`define CLK_RATE_KHZ      100000
`define CLK_PER_BUS_BIT   ((`CLK_RATE_KHZ) / (`BUS_RATE_KHZ))
`endif

// File: rtl/i2c_register_port.v
// two-wire slave control port with 16-bit register words and burst access
// assumes the bus pins pass an external open-drain pad; the core logic
// owns general registers through a plain write strobe and read data port
`timescale 1ns/1ns
`include "i2c_port_defines.vh"
module i2c_register_port (
  // clock and reset
  input  wire        REF_CLK_IN,
  input  wire        RST_IN,
  // bus pins, open drain
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_OUT,
  // address straps
  input  wire        ADDR_STRAP_LSB_IN,
  input  wire        ADDR_STRAP_BIT1_IN,
  // core status
  input  wire        UV_EVENT_IN,
  input  wire [9:0]  SUPPLY_VOLTAGE_CODE_IN,
  input  wire [7:0]  DIE_TEMP_CODE_IN,
  input  wire [15:0] REG_RDATA_IN,
  // general register write access, interrupt flag and busy status
  output reg  [7:0]  REG_ADDR_OUT,
  output reg  [15:0] REG_WDATA_OUT,
  output reg         REG_WE_OUT,
  output reg         UNDERVOLTAGE_IRQ_FLAG_OUT,
  output reg         BUSY_OUT
);

// ====================================================================
// state codes
localparam ST_IDLE  = 3'h0;
localparam ST_ADDR  = 3'h1;
localparam ST_RX    = 3'h2;
localparam ST_ACK   = 3'h3;
localparam ST_TX    = 3'h4;
localparam ST_MACK  = 3'h5;
localparam ST_WAIT  = 3'h6;

// ====================================================================
// input synchronisers
// scl and sda share the same two-flop lag, so their relative order
// is kept; a skew between them would turn a data change into a false
// start or stop
reg [1:0] scl_sync_q;
reg [1:0] sda_sync_q;
reg       scl_q;
reg       sda_q;

always @(posedge REF_CLK_IN or posedge RST_IN) begin
  if (RST_IN) begin
    scl_sync_q <= 2'h3;
    sda_sync_q <= 2'h3;
    scl_q      <= 1'b1;
    sda_q      <= 1'b1;
  end else begin
    scl_sync_q <= {scl_sync_q[0], SCL_IN};
    sda_sync_q <= {sda_sync_q[0], SDA_IN};
    scl_q      <= scl_sync_q[1];
    sda_q      <= sda_sync_q[1];
  end
end

wire scl_s    = scl_sync_q[1];
wire sda_s    = sda_sync_q[1];
wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
// clock sampled high on both samples so a clock edge never looks like start/stop
wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

// straps: the synchronised copies are caught every cycle after reset
// moving a strap mid-run changes the address a few cycles later; a
// transfer already past its address byte is not affected
reg [1:0] strap_sync_q;
reg [1:0] strap_q;
always @(posedge REF_CLK_IN or posedge RST_IN) begin
  if (RST_IN) begin
    strap_sync_q <= 2'h0;
    strap_q      <= 2'h0;
  end else begin
    strap_sync_q <= {ADDR_STRAP_BIT1_IN, ADDR_STRAP_LSB_IN};
    strap_q      <= strap_sync_q;
  end
end
wire [6:0] my_addr = {`ADDR_UPPER, strap_q};

// under-voltage event synchroniser
reg [1:0] uv_sync_q;
always @(posedge REF_CLK_IN or posedge RST_IN) begin
  if (RST_IN)
    uv_sync_q <= 2'h0;
  else
    uv_sync_q <= {uv_sync_q[0], UV_EVENT_IN};
end

// ====================================================================
// protocol engine
// timing: pins reach the engine through two flops, so each scl edge is
// seen about three clock cycles late. the engine moves its drive at the
// seen falling edge itself, well inside the low phase, and reads
// the data line on the seen rising edge, where both lines share one lag.
// limitation: the low phase of scl must last more than three clock cycles;
// a shorter one would let the drive change while the clock is high.
// a start or stop always wins over the byte engine, whatever the state.
// the idle code has no case item of its own and lands in the default.
reg [2:0]  state_q;
reg [2:0]  bitcnt_q;
reg [7:0]  shift_q;
reg        rw_q;
reg        ptr_done_q;
reg        hi_done_q;
reg        tx_lo_q;
reg [7:0]  ptr_q;
reg [7:0]  hi_byte_q;
reg [15:0] txword_q;
reg        ack_drive_q;
reg        ack_seen_q;
reg        irq_read_q;

// read data multiplexer: local status registers overlay the general space
// it follows the pointer with no register, so a pointer step made while
// scl is high has the new word ready at the next falling edge
reg [15:0] rd_word;
always @* begin
  rd_word = REG_RDATA_IN;
  case (ptr_q)
    `REG_IRQ_INDEX:  rd_word = {1'b0, UNDERVOLTAGE_IRQ_FLAG_OUT, 14'h0000};
    `REG_VBAT_INDEX: rd_word = {6'h00, SUPPLY_VOLTAGE_CODE_IN};
    `REG_TEMP_INDEX: rd_word = {{8{DIE_TEMP_CODE_IN[7]}}, DIE_TEMP_CODE_IN};
    default:         rd_word = REG_RDATA_IN;
  endcase
end

// a start or stop in the middle of a byte drops the byte; the register pointer is kept
always @(posedge REF_CLK_IN or posedge RST_IN) begin
  if (RST_IN) begin
    state_q       <= ST_IDLE;
    bitcnt_q      <= 3'h0;
    shift_q       <= 8'h00;
    rw_q          <= 1'b0;
    ptr_done_q    <= 1'b0;
    hi_done_q     <= 1'b0;
    tx_lo_q       <= 1'b0;
    ptr_q         <= 8'h00;
    hi_byte_q     <= 8'h00;
    txword_q      <= 16'h0000;
    ack_drive_q   <= 1'b0;
    ack_seen_q    <= 1'b0;
    irq_read_q    <= 1'b0;
    SDA_OUT       <= 1'b0;
    SDA_OE_OUT    <= 1'b0;
    REG_ADDR_OUT  <= 8'h00;
    REG_WDATA_OUT <= 16'h0000;
    REG_WE_OUT    <= 1'b0;
    BUSY_OUT      <= 1'b0;
  end else begin
    REG_WE_OUT <= 1'b0;
    irq_read_q <= 1'b0;
    SDA_OUT    <= 1'b0;
    if (start_ev) begin
      state_q    <= ST_ADDR;
      bitcnt_q   <= 3'h0;
      SDA_OE_OUT <= 1'b0;
      BUSY_OUT   <= 1'b1;
      hi_done_q  <= 1'b0;
      ptr_done_q <= 1'b0;
      ack_seen_q <= 1'b0;
      tx_lo_q    <= 1'b0;
    end else if (stop_ev) begin
      state_q    <= ST_IDLE;
      SDA_OE_OUT <= 1'b0;
      BUSY_OUT   <= 1'b0;
    end else begin
      case (state_q)
        // address and received bytes: shift on each seen rising edge, decide
        // at the falling edge that ends the eighth bit
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_q  <= {shift_q[6:0], sda_s};
            bitcnt_q <= bitcnt_q + 3'h1;
          end
          if (scl_fall && bitcnt_q == 3'h0 && ack_seen_q) begin
            ack_seen_q <= 1'b0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == my_addr) begin
                rw_q        <= shift_q[0];
                ack_drive_q <= shift_q[0];
                SDA_OE_OUT  <= 1'b1;
                state_q     <= ST_ACK;
                txword_q    <= rd_word;
                irq_read_q  <= shift_q[0] && (ptr_q == `REG_IRQ_INDEX);
              end else begin
                state_q <= ST_WAIT;
              end
            end else begin
              SDA_OE_OUT  <= 1'b1;
              ack_drive_q <= 1'b0;
              state_q     <= ST_ACK;
              if (!ptr_done_q) begin
                ptr_q      <= shift_q;
                ptr_done_q <= 1'b1;
              end else if (!hi_done_q) begin
                hi_byte_q <= shift_q;
                hi_done_q <= 1'b1;
              end else begin
                REG_ADDR_OUT  <= ptr_q;
                REG_WDATA_OUT <= {hi_byte_q, shift_q};
                REG_WE_OUT    <= 1'b1;
                irq_read_q    <= 1'b0;
                hi_done_q     <= 1'b0;
                ptr_q         <= ptr_q + 8'h01;
              end
            end
          end else if (scl_rise && bitcnt_q == 3'h7) begin
            ack_seen_q <= 1'b1;
          end
        end

        // ninth clock of a received byte: the acknowledge is already driven
        // and is held until the clock falls again
        ST_ACK: begin
          // hold the acknowledge low through the ninth clock
          if (scl_fall) begin
            bitcnt_q <= 3'h0;
            if (ack_drive_q) begin
              state_q    <= ST_TX;
              tx_lo_q    <= 1'b0;
              SDA_OE_OUT <= ~rd_word_bit(txword_q, 1'b0, 3'h0);
            end else begin
              state_q    <= ST_RX;
              SDA_OE_OUT <= 1'b0;
            end
          end
        end

        // sending: each seen falling edge puts out the next bit, and the
        // eighth one lets the line go for the master's answer
        ST_TX: begin
          if (scl_fall) begin
            bitcnt_q <= bitcnt_q + 3'h1;
            if (bitcnt_q == 3'h7) begin
              SDA_OE_OUT <= 1'b0;
              state_q    <= ST_MACK;
            end else begin
              SDA_OE_OUT <= ~rd_word_bit(txword_q, tx_lo_q, bitcnt_q + 3'h1);
            end
          end
        end
        // master's answer to a sent byte; an ack after the low byte steps the
        // pointer while the clock is high, so the next word is ready at the fall
        ST_MACK: begin
          if (scl_rise) begin
            ack_seen_q <= ~sda_s;
            if (tx_lo_q && !sda_s) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
          if (scl_fall) begin
            bitcnt_q   <= 3'h0;
            ack_seen_q <= 1'b0;
            if (!ack_seen_q) begin
              state_q <= ST_WAIT;
            end else if (!tx_lo_q) begin
              tx_lo_q    <= 1'b1;
              state_q    <= ST_TX;
              SDA_OE_OUT <= ~txword_q[7];
            end else begin
              tx_lo_q    <= 1'b0;
              state_q    <= ST_TX;
              txword_q   <= rd_word;
              irq_read_q <= (ptr_q == `REG_IRQ_INDEX);
              SDA_OE_OUT <= ~rd_word[15];
            end
          end
        end

        // not addressed, or read ended by the master: stay off the bus until
        // the next start or stop
        ST_WAIT: begin
          SDA_OE_OUT <= 1'b0;
        end

        // idle and unused codes: fall back to idle with the data line released
        default: begin
          state_q    <= ST_IDLE;
          SDA_OE_OUT <= 1'b0;
        end
      endcase
    end
  end
end

// bit of the outgoing word, MSB first
// idx counts bits already sent within the byte; lo picks the low byte
function rd_word_bit;
  input [15:0] w;
  input        lo;
  input [2:0]  idx;
  begin
    rd_word_bit = lo ? w[3'h7 - idx] : w[4'hF - {1'b0, idx}];
  end
endfunction

// ====================================================================
// under-voltage interrupt flag: an event wins over a read clear
// the clear comes when the word holding the flag is loaded for sending,
// so the flag value already on its way out is never lost; a held event
// keeps the flag set through any number of reads
always @(posedge REF_CLK_IN or posedge RST_IN) begin
  if (RST_IN)
    UNDERVOLTAGE_IRQ_FLAG_OUT <= 1'b0;
  else if (uv_sync_q[1])
    UNDERVOLTAGE_IRQ_FLAG_OUT <= 1'b1;
  else if (irq_read_q)
    UNDERVOLTAGE_IRQ_FLAG_OUT <= 1'b0;
end

endmodule

// File: sim/i2c_port_chk.sv
// checker of the serial port's pin timing
// assumes binding to i2c_register_port, bus idle high
`timescale 1ns/1ns
module i2c_port_chk (
  input wire REF_CLK_IN,
  input wire RST_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_OUT,
  input wire UV_EVENT_IN,
  input wire REG_WE_OUT,
  input wire UNDERVOLTAGE_IRQ_FLAG_OUT,
  input wire BUSY_OUT
);
  reg [1:0] scl_q;
  reg [1:0] sda_q;
  // ======
  // own copy of the pin sync, so start and stop are seen as the port sees them
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
    end else begin
      scl_q <= {scl_q[0], SCL_IN};
      sda_q <= {sda_q[0], SDA_IN};
    end
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_pin_low: assert property (!SDA_OUT) else $error("data pin drives high");
  a_we_single: assert property (REG_WE_OUT |=> !REG_WE_OUT) else $error("write strobe too long");
  a_we_busy: assert property (REG_WE_OUT |-> BUSY_OUT) else $error("write outside transfer");
  a_busy_start: assert property (scl_q[1] && $fell(sda_q[1]) |-> ##[1:8] BUSY_OUT)
    else $error("start not taken");
  a_busy_stop: assert property (scl_q[1] && $rose(sda_q[1]) |-> ##[1:8] !BUSY_OUT)
    else $error("stop not taken");
  a_oe_scl_low: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN) else $error("drive moved, clock high");
  a_idle_quiet: assert property (!BUSY_OUT |-> !SDA_OE_OUT) else $error("drive while idle");
  a_uv_set: assert property (UV_EVENT_IN |-> ##[1:4] UNDERVOLTAGE_IRQ_FLAG_OUT) else $error("flag not set");
  a_flag_clear: assert property ($fell(UNDERVOLTAGE_IRQ_FLAG_OUT) |-> BUSY_OUT) else $error("flag lost");
  cover property (REG_WE_OUT);
  cover property ($rose(SDA_OE_OUT));
  cover property ($fell(UNDERVOLTAGE_IRQ_FLAG_OUT));
endmodule
bind i2c_register_port i2c_port_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .UV_EVENT_IN(UV_EVENT_IN),
  .REG_WE_OUT(REG_WE_OUT), .UNDERVOLTAGE_IRQ_FLAG_OUT(UNDERVOLTAGE_IRQ_FLAG_OUT), .BUSY_OUT(BUSY_OUT));

// File: sim/i2c_host_model.sv
// bus master model: start, stop and nine-bit transfers
// assumes a pull-up wire built from pull and the port's drive
`timescale 1ns/1ns
module i2c_host_model (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // ======
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // 80 ns bit: 40 ns low, 40 ns high; the port drives 25 ns after a fall
  task bitx(input logic b, output logic r);
    begin
      pull = ~b;
      wt(3);
      scl = 1'b1;
      wt(2);
      r = sda;
      wt(2);
      scl = 1'b0;
      wt(1);
    end
  endtask
  task xfer(input [7:0] tx, input logic b9, output [7:0] rx, output logic r9);
    integer i;
    begin
      for (i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(b9, r9);
    end
  endtask
  task start;
    begin
      pull = 1'b0;
      wt(3);
      scl = 1'b1;
      wt(3);
      pull = 1'b1;
      wt(3);
      scl = 1'b0;
      wt(1);
    end
  endtask
  task stop;
    begin
      pull = 1'b1;
      wt(3);
      scl = 1'b1;
      wt(3);
      pull = 1'b0;
      wt(3);
    end
  endtask
endmodule

// File: sim/tb_top.sv
// bench of the serial register port through a bus master model
// assumes a 100 MHz clock and a pull-up on the data wire
`timescale 1ns/1ns
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         lsb = 1'b0;
  reg         bit1 = 1'b0;
  reg         uv = 1'b0;
  wire        scl, pull, oe, sdo, we, flag, busy;
  wire        sda = ~(pull | (oe & ~sdo));
  wire [7:0]  wadr;
  wire [15:0] wdat;
  integer     bad_count = 0;
  integer     n_checks = 0;
  integer     we_n = 0;
  reg  [7:0]  wa, rx;
  reg  [15:0] wd, w0, w1;
  reg         a9;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (we) begin
      we_n <= we_n + 1;
      wa <= wadr;
      wd <= wdat;
    end
  end
  i2c_register_port u_i2c_register_port (.REF_CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sdo), .SDA_OE_OUT(oe), .ADDR_STRAP_LSB_IN(lsb), .ADDR_STRAP_BIT1_IN(bit1), .UV_EVENT_IN(uv),
    .SUPPLY_VOLTAGE_CODE_IN(10'h153), .DIE_TEMP_CODE_IN(8'hE7), .REG_RDATA_IN(16'h5A5A), .REG_ADDR_OUT(wadr),
    .REG_WDATA_OUT(wdat), .REG_WE_OUT(we), .UNDERVOLTAGE_IRQ_FLAG_OUT(flag), .BUSY_OUT(busy));
  i2c_host_model m_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  // ======
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks++;
      if (g !== e) begin
        bad_count++;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task put(input [7:0] b, input logic ak);
    begin
      m_host.xfer(b, 1'b1, rx, a9);
      chk("ack", {15'h0, ~ak}, {15'h0, a9});
    end
  endtask
  task get(output [15:0] w, input logic nak);
    begin
      m_host.xfer(8'hFF, 1'b0, w[15:8], a9);
      m_host.xfer(8'hFF, nak, w[7:0], a9);
    end
  endtask
  task rd(input [7:0] p, output [15:0] w);
    begin
      m_host.start;
      put(8'h68, 1'b1);
      put(p, 1'b1);
      m_host.start;
      put(8'h69, 1'b1);
      get(w, 1'b1);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results;
  end
  // ======
  initial begin
    integer i;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (i = 0; i < 4; i++) begin
      {bit1, lsb} = i[1:0];
      m_host.start;
      put({5'h0D, i[1:0], 1'b0}, 1'b1);
      m_host.stop;
    end
    {bit1, lsb} = 2'h0;
    m_host.start;
    put(8'h70, 1'b0);
    put(8'h10, 1'b0);
    m_host.stop;
    chk("writes", 16'h0, we_n[15:0]);
    $display("test address done");
    m_host.start;
    put(8'h68, 1'b1);
    put(8'h10, 1'b1);
    put(8'hAB, 1'b1);
    put(8'hCD, 1'b1);
    chk("waddr", 16'h0010, {8'h0, wa});
    chk("wdata", 16'hABCD, wd);
    put(8'h12, 1'b1);
    put(8'h34, 1'b1);
    chk("waddr", 16'h0011, {8'h0, wa});
    chk("wdata", 16'h1234, wd);
    m_host.stop;
    m_host.start;
    put(8'h68, 1'b1);
    put(8'h20, 1'b1);
    put(8'h55, 1'b1);
    m_host.start;
    m_host.stop;
    chk("writes", 16'h2, we_n[15:0]);
    chk("busy", 16'h0, {15'h0, busy});
    $display("test write done");
    uv = 1'b1;
    m_host.wt(5);
    uv = 1'b0;
    m_host.wt(5);
    chk("flag", 16'h1, {15'h0, flag});
    m_host.start;
    put(8'h68, 1'b1);
    put(8'h6D, 1'b1);
    m_host.stop;
    m_host.start;
    put(8'h69, 1'b1);
    get(w0, 1'b0);
    get(w1, 1'b1);
    m_host.stop;
    chk("vcode", 16'h0153, w0);
    chk("tcode", 16'hFFE7, w1);
    rd(8'h02, w0);
    m_host.stop;
    chk("uv bit", 16'h1, {15'h0, w0[14]});
    chk("flag", 16'h0, {15'h0, flag});
    rd(8'h02, w0);
    m_host.xfer(8'hFF, 1'b1, rx, a9);
    m_host.stop;
    chk("after nack", 16'h00FF, {8'h0, rx});
    chk("uv bit", 16'h0, {15'h0, w0[14]});
    $display("test read done");
    results;
  end
endmodule
